// file: tcat_pkg.sv
package tcat_pkg;

   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned CLK_PER_MS = CLK_HZ / 1000;
   // Fixed drop-off reset time
   localparam int unsigned RESET_TIME_MS = 500;
   localparam int unsigned RESET_CYCLES = RESET_TIME_MS * CLK_PER_MS;
   // Default operate delay, range 20 to 300000 ms
   localparam int unsigned OPERATE_DELAY_DEF_MS = 3000;
   localparam int unsigned OPERATE_DELAY_MIN_MS = 20;
   localparam int unsigned OPERATE_DELAY_MAX_MS = 300000;

   // ----------------------------------------------------------------
   // Register map (word aligned byte addresses)
   // ----------------------------------------------------------------
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_DELAY = 4'h4;
   localparam logic [3:0] ADDR_STATUS = 4'h8;
   localparam logic [3:0] ADDR_TIMER = 4'hC;
   localparam int unsigned CTRL_ON_BIT = 0;
   localparam logic CTRL_ON_RESET = 1'b1;
   localparam int unsigned ST_ALARM_BIT = 0;
   localparam int unsigned ST_RUN_BIT = 1;
   localparam int unsigned ST_DROP_BIT = 2;
   localparam int unsigned ST_BLOCK_BIT = 3;
   localparam int unsigned ST_FAIL_BIT = 4;
   localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

   typedef enum logic [1:0] {
      TCAT_IDLE,
      TCAT_RUN,
      TCAT_DROP,
      TCAT_ALARM
   } tcat_state_t;

   typedef struct packed {
      logic [3:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } tcat_av_req_t;

   typedef struct packed {
      logic [31:0] readdata;
      logic waitrequest;
   } tcat_av_rsp_t;

endpackage

// file: tcat_top.sv
// Functional notes
// - Supervision runs only when operation setting is on; off disables all activity.
// - A failure indication from the status input starts the operate timer.
// - Timer counts to the operate delay, then the alarm output asserts.
// - Failure drop-off mid count starts fixed 0.5 s reset timer, then clears timer.
// - Block input asserted means alarm never asserts.
// - Asserting block immediately drops alarm and resets the operate timer.
// - After operating, alarm clears once the failure indication is gone.
//
// The placing of the registers and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module tcat_top #(
   parameter int unsigned RESET_CYC = tcat_pkg::RESET_CYCLES,
   parameter int unsigned MS_CYC = tcat_pkg::CLK_PER_MS
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic clk_en_i,
   input wire logic fail_i,
   input wire logic block_i,
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   output logic alarm_o
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      tcat_pkg::tcat_state_t fsm;
      logic on;
      logic [18:0] delay_ms;
      logic [18:0] op_ms;
      logic [15:0] op_sub;
      logic [31:0] rst_cnt;
      logic alarm;
      logic [31:0] rdata;
      logic waitreq;
   } tcat_st_t;

   tcat_st_t st_reg;
   tcat_st_t st_next;
   tcat_pkg::tcat_av_req_t req;

   assign req = '{address: avs_address_i, read: avs_read_i, write: avs_write_i,
                  writedata: avs_writedata_i, byteenable: avs_byteenable_i};

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   // 0x0 control: bit 0 turns supervision on, set after reset
   // 0x4 delay: operate delay in ms, clamped into the legal range
   // 0x8 status: alarm, running, drop-off timing, block, failure
   // 0xC elapsed: whole ms counted so far by the operate timer
   // A write needs byte lane 0; stores without it are dropped so that a
   // partial store can never leave the delay half updated.

   // Status word as software sees it; unlisted bits read as zero
   function automatic logic [31:0] status_word(
      input tcat_pkg::tcat_state_t fsm,
      input logic alarm,
      input logic block,
      input logic fail
   );
      status_word = 32'h0000_0000;
      status_word[tcat_pkg::ST_ALARM_BIT] = alarm;
      status_word[tcat_pkg::ST_RUN_BIT] = (fsm == tcat_pkg::TCAT_RUN);
      status_word[tcat_pkg::ST_DROP_BIT] = (fsm == tcat_pkg::TCAT_DROP);
      status_word[tcat_pkg::ST_BLOCK_BIT] = block;
      status_word[tcat_pkg::ST_FAIL_BIT] = fail;
   endfunction

   // Read multiplexer; unmapped offsets return a fixed pattern
   function automatic logic [31:0] read_word(
      input tcat_st_t s,
      input logic [3:0] address,
      input logic block,
      input logic fail
   );
      case (address)
         tcat_pkg::ADDR_CTRL: read_word = 32'(s.on);
         tcat_pkg::ADDR_DELAY: read_word = 32'(s.delay_ms);
         tcat_pkg::ADDR_STATUS: read_word = status_word(s.fsm, s.alarm, block, fail);
         tcat_pkg::ADDR_TIMER: read_word = 32'(s.op_ms);
         default: read_word = tcat_pkg::UNMAPPED_READ;
      endcase
   endfunction

   // Clamp a written delay into the legal setting range
   function automatic logic [18:0] clamp_delay(input logic [31:0] v);
      if (v < 32'(tcat_pkg::OPERATE_DELAY_MIN_MS))
         clamp_delay = 19'(tcat_pkg::OPERATE_DELAY_MIN_MS);
      else if (v > 32'(tcat_pkg::OPERATE_DELAY_MAX_MS))
         clamp_delay = 19'(tcat_pkg::OPERATE_DELAY_MAX_MS);
      else
         clamp_delay = v[18:0];
   endfunction

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      logic acc;
      logic op_done;
      acc = 1'b0;
      op_done = 1'b0;
      st_next = st_reg;

      // ----------------------------------------------------------------
      // Bus handshake
      // ----------------------------------------------------------------
      // A request is taken while waitrequest stands high and answered one
      // cycle later; waitrequest is its own flop so the port has no gate
      // in front of it, at the cost of one wait state on every access.
      acc = (req.read || req.write) && st_reg.waitreq;
      st_next.waitreq = !acc;

      // ----------------------------------------------------------------
      // Register writes
      // ----------------------------------------------------------------
      if (req.write && acc && req.byteenable[0])
      begin
         case (req.address)
            tcat_pkg::ADDR_CTRL: st_next.on = req.writedata[tcat_pkg::CTRL_ON_BIT];
            tcat_pkg::ADDR_DELAY: st_next.delay_ms = clamp_delay(req.writedata);
            default: ;
         endcase
      end
      // ----------------------------------------------------------------
      // Register reads
      // ----------------------------------------------------------------
      // Read data is captured when the request is taken and then stands
      // until the next read
      if (req.read && acc)
         st_next.rdata = read_word(st_reg, req.address, block_i, fail_i);

      // ----------------------------------------------------------------
      // Supervision timer
      // ----------------------------------------------------------------
      // IDLE waits for a failure, RUN counts whole milliseconds, DROP runs
      // the fixed reset time after a drop-off, ALARM holds the output.
      // Off and block are checked first so that neither can be outrun by
      // a state that happens to finish in the same cycle.
      op_done = (st_reg.op_ms >= st_reg.delay_ms);
      if (!st_reg.on)
      begin
         // Off: state, timers and alarm cleared and held
         st_next.fsm = tcat_pkg::TCAT_IDLE;
         st_next.op_ms = '0;
         st_next.op_sub = '0;
         st_next.rst_cnt = '0;
         st_next.alarm = 1'b0;
      end
      else if (block_i)
      begin
         // Block wins over every state, though off is checked first, and restarts timing from zero
         st_next.fsm = tcat_pkg::TCAT_IDLE;
         st_next.op_ms = '0;
         st_next.op_sub = '0;
         st_next.rst_cnt = '0;
         st_next.alarm = 1'b0;
      end
      else
      begin
         case (st_reg.fsm)
            tcat_pkg::TCAT_IDLE:
            begin
               if (fail_i)
                  st_next.fsm = tcat_pkg::TCAT_RUN;
            end
            tcat_pkg::TCAT_RUN:
            begin
               if (!fail_i)
               begin
                  st_next.fsm = tcat_pkg::TCAT_DROP;
                  st_next.rst_cnt = '0;
               end
               else if (op_done)
               begin
                  st_next.fsm = tcat_pkg::TCAT_ALARM;
                  st_next.alarm = 1'b1;
               end
               else if (st_reg.op_sub == 16'(MS_CYC - 1))
               begin
                  st_next.op_sub = '0;
                  st_next.op_ms = st_reg.op_ms + 19'h00001;
               end
               else
                  st_next.op_sub = st_reg.op_sub + 16'h0001;
            end
            tcat_pkg::TCAT_DROP:
            begin
               // Elapsed time is kept so a brief drop-off does not restart timing
               if (fail_i)
                  st_next.fsm = tcat_pkg::TCAT_RUN;
               else if (st_reg.rst_cnt >= 32'(RESET_CYC - 1))
               begin
                  st_next.fsm = tcat_pkg::TCAT_IDLE;
                  st_next.op_ms = '0;
                  st_next.op_sub = '0;
                  st_next.rst_cnt = '0;
               end
               else
                  st_next.rst_cnt = st_reg.rst_cnt + 32'h0000_0001;
            end
            tcat_pkg::TCAT_ALARM:
            begin
               if (!fail_i)
               begin
                  st_next.fsm = tcat_pkg::TCAT_IDLE;
                  st_next.alarm = 1'b0;
                  st_next.op_ms = '0;
                  st_next.op_sub = '0;
               end
            end
            default: st_next.fsm = tcat_pkg::TCAT_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         st_reg.fsm <= tcat_pkg::TCAT_IDLE;
         st_reg.on <= tcat_pkg::CTRL_ON_RESET;
         st_reg.delay_ms <= 19'(tcat_pkg::OPERATE_DELAY_DEF_MS);
         st_reg.op_ms <= '0;
         st_reg.op_sub <= '0;
         st_reg.rst_cnt <= '0;
         st_reg.alarm <= 1'b0;
         st_reg.rdata <= '0;
         st_reg.waitreq <= 1'b1;
      end
      else if (clk_en_i)
         st_reg <= st_next;
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign alarm_o = st_reg.alarm;
   assign avs_readdata_o = st_reg.rdata;
   assign avs_waitrequest_o = st_reg.waitreq;

endmodule

`default_nettype wire

// file: tcat_sense_model.sv
`timescale 1ns/1ps
`default_nettype none
module tcat_sense_model (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic fail_req_i,
   input wire logic block_req_i,
   output logic fail_o,
   output logic block_o
);
   // Front end settles its contact status once per clock, never mid-cycle
   always_ff @(posedge clk_i or negedge arst_n_i)
      if (!arst_n_i)
         {fail_o, block_o} <= 2'b00;
      else
         {fail_o, block_o} <= {fail_req_i, block_req_i};
endmodule
`default_nettype wire

// file: tcat_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module tcat_checker #(
   parameter int unsigned MS_CYC = tcat_pkg::CLK_PER_MS
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic clk_en_i,
   input wire logic fail_i,
   input wire logic block_i,
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   input wire logic alarm_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   // Lower bound only: drop-off and off are not modelled, so it never undercounts
   int unsigned fail_cnt;
   always_ff @(posedge clk_i or negedge arst_n_i)
      if (!arst_n_i)
         fail_cnt <= 0;
      else if (block_i && clk_en_i)
         fail_cnt <= 0;
      else if (fail_i && clk_en_i)
         fail_cnt <= fail_cnt + 1;
   a_block_no_alarm: assert property (block_i && clk_en_i |=> !alarm_o)
      else $error("alarm high while blocked");
   a_fail_gone_clear: assert property (!fail_i && clk_en_i |=> !alarm_o)
      else $error("alarm stays without failure");
   a_alarm_needs_fail: assert property ($rose(alarm_o) |-> $past(fail_i))
      else $error("alarm rose without failure");
   a_alarm_min_delay: assert property
      ($rose(alarm_o) |-> fail_cnt >= tcat_pkg::OPERATE_DELAY_MIN_MS * MS_CYC)
      else $error("alarm before shortest delay");
   a_frozen_state: assert property
      (!clk_en_i |=> $stable(alarm_o) && $stable(avs_waitrequest_o))
      else $error("state moved while frozen");
   a_wait_one_cycle: assert property (!avs_waitrequest_o && clk_en_i |=> avs_waitrequest_o)
      else $error("waitrequest low too long");
   a_bus_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
      && clk_en_i |-> ##[1:2] !avs_waitrequest_o)
      else $error("bus access not answered");
   a_unmapped_zero: assert property (avs_read_i && !avs_waitrequest_o
      && avs_address_i[1:0] != 2'h0 |-> avs_readdata_o == 32'h0)
      else $error("unmapped read not zero");
endmodule
`default_nettype wire

// file: tb_trip_circuit_alarm_timer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_trip_circuit_alarm_timer;
   localparam int unsigned MS = 4;
   localparam int unsigned RC = 50;
   logic clk, arst_n, clk_en, want_fail, want_block, fail, block, rd, wr, wreq, alarm;
   logic [3:0] addr;
   logic [31:0] wdata, rdata, q;
   int mismatches = 0;
   int total_checks = 0;
   int n;
   tcat_sense_model far_u (.clk_i(clk), .arst_n_i(arst_n), .fail_req_i(want_fail),
      .block_req_i(want_block), .fail_o(fail), .block_o(block));
   tcat_top #(.RESET_CYC(RC), .MS_CYC(MS)) dut_u (.clk_i(clk), .arst_n_i(arst_n),
      .clk_en_i(clk_en), .fail_i(fail), .block_i(block), .avs_address_i(addr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
      .avs_byteenable_i(4'hF), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
      .alarm_o(alarm));
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      total_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED %0t %s got %h", $time, m, got);
      end
   endtask
   task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      addr <= a;
      wr <= w;
      rd <= !w;
      wdata <= d;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (wreq !== 1'b0 && k < 20);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      if (k >= 20)
      begin
         mismatches++;
         summarize();
      end
   endtask
   task automatic wait_alarm;
      n = 0;
      while (alarm !== 1'b1 && n < 400)
      begin
         @(posedge clk);
         n++;
      end
      chk({31'h0, n >= 80 && n <= 90}, 32'h1, "operate time");
      if (n >= 400)
         summarize();
   endtask
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial
   begin
      {arst_n, want_fail, want_block, rd, wr, addr, wdata} = '0;
      clk_en = 1'b1;
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      bus(tcat_pkg::ADDR_CTRL, 0, 0); chk(q, 32'h1, "ctrl reset");
      bus(tcat_pkg::ADDR_DELAY, 0, 0); chk(q, 32'h0000_0BB8, "delay reset");
      bus(4'h2, 0, 0); chk(q, 32'h0, "unmapped");
      bus(tcat_pkg::ADDR_DELAY, 1, 32'h0000_0014);
      want_fail <= 1'b1;
      wait_alarm();
      want_fail <= 1'b0;
      repeat (3) @(posedge clk);
      chk({31'h0, alarm}, 32'h0, "drop clears alarm");
      $display("test operate done");
      want_fail <= 1'b1;
      repeat (40) @(posedge clk);
      want_fail <= 1'b0;
      repeat (5) @(posedge clk);
      bus(tcat_pkg::ADDR_STATUS, 0, 0); chk(q, 32'h0000_0004, "drop-off timing");
      repeat (RC + 10) @(posedge clk);
      bus(tcat_pkg::ADDR_TIMER, 0, 0); chk(q, 32'h0, "reset time clears timer");
      want_fail <= 1'b1;
      wait_alarm();
      $display("test dropoff done");
      want_block <= 1'b1;
      clk_en <= 1'b0;
      repeat (5) @(posedge clk);
      clk_en <= 1'b1;
      repeat (3) @(posedge clk);
      chk({31'h0, alarm}, 32'h0, "block drops alarm");
      bus(tcat_pkg::ADDR_TIMER, 0, 0); chk(q, 32'h0, "block clears timer");
      repeat (100) @(posedge clk);
      chk({31'h0, alarm}, 32'h0, "blocked stays low");
      bus(tcat_pkg::ADDR_STATUS, 0, 0); chk(q, 32'h0000_0018, "blocked status");
      want_block <= 1'b0;
      $display("test block done");
      bus(tcat_pkg::ADDR_CTRL, 1, 32'h0);
      repeat (120) @(posedge clk);
      chk({31'h0, alarm}, 32'h0, "off holds alarm");
      bus(tcat_pkg::ADDR_TIMER, 0, 0); chk(q, 32'h0, "off clears timer");
      $display("test off done");
      summarize();
   end
endmodule
bind tcat_top tcat_checker #(.MS_CYC(MS_CYC)) chk_u (.clk_i(clk_i), .arst_n_i(arst_n_i),
   .clk_en_i(clk_en_i), .fail_i(fail_i), .block_i(block_i), .avs_address_i(avs_address_i),
   .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
   .avs_waitrequest_o(avs_waitrequest_o), .alarm_o(alarm_o));
`default_nettype wire
